// *** design/flash_command_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module flash_command_host #(
    parameter int ABORT_WAIT = flash_host_pkg::ABORT_CYCLES,
    parameter int SUSPEND_WAIT = flash_host_pkg::SUSPEND_CYCLES,
    parameter int BLOCK_GAP = flash_host_pkg::BLOCK_GAP_CYCLES
) (
    // Clock and control.
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Command port.
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [3:0] cmd_op,
    input wire logic [18:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic bypass_active,
    output logic block_window_open,
    // Flash pins.
    output logic chip_en_n,
    output logic out_en_n,
    output logic write_en_n,
    output logic [18:0] byte_address_lines,
    output logic [7:0] byte_data_lines_out,
    output logic byte_data_lines_oe,
    input wire logic [7:0] byte_data_lines_in,
    output logic elevated_id_voltage
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_WRITE = 3'b001, ST_WAIT = 3'b011, ST_PAUSE = 3'b010,
        ST_DONE = 3'b110
    } state_t;
    typedef struct packed {
        state_t st;
        logic [2:0] idx;
        logic [2:0] len;
        logic rd;
        flash_host_pkg::op_t op;
        logic [18:0] addr;
        logic [7:0] data;
        logic [31:0] wait_cnt;
        logic [31:0] gap_cnt;
        logic bypass;
        logic id_pin;
        logic [7:0] rdata;
        logic rsp;
    } host_t;
    host_t s_reg, s_next;
    flash_cycle_if cyc();

    // Length of the write sequence for each command.
    function automatic logic [2:0] seq_len(input flash_host_pkg::op_t op);
        unique case (op)
            flash_host_pkg::OP_RESET, flash_host_pkg::OP_SUSPEND,
            flash_host_pkg::OP_RESUME, flash_host_pkg::OP_BLOCK_ADD: seq_len = 3'd1;
            flash_host_pkg::OP_BYP_PROGRAM, flash_host_pkg::OP_BYP_EXIT: seq_len = 3'd2;
            flash_host_pkg::OP_RESET3, flash_host_pkg::OP_AUTOSEL,
            flash_host_pkg::OP_BYPASS: seq_len = 3'd3;
            flash_host_pkg::OP_PROGRAM: seq_len = 3'd4;
            flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_BLOCK_ERASE: seq_len = 3'd6;
            default: seq_len = 3'd0;
        endcase
    endfunction

    // Address and data of write number i; the unlock pair opens the long forms.
    function automatic logic [26:0] seq_word(input flash_host_pkg::op_t op,
        input logic [2:0] i, input logic [18:0] a, input logic [7:0] d);
        logic [2:0] k;
        k = (i > 3'd2) ? i - 3'd3 : i;
        seq_word = {a, d};
        unique case (op)
            flash_host_pkg::OP_RESET, flash_host_pkg::OP_BLOCK_ADD:
                seq_word = {a, (op == flash_host_pkg::OP_RESET) ?
                    flash_host_pkg::CMD_RESET : flash_host_pkg::CMD_BLOCK_ERASE};
            flash_host_pkg::OP_SUSPEND: seq_word = {a, flash_host_pkg::CMD_SUSPEND};
            flash_host_pkg::OP_RESUME: seq_word = {a, flash_host_pkg::CMD_RESUME};
            flash_host_pkg::OP_BYP_PROGRAM:
                if (i == 3'd0) seq_word = {a, flash_host_pkg::CMD_PROGRAM};
            flash_host_pkg::OP_BYP_EXIT:
                seq_word = {a, (i == 3'd0) ? flash_host_pkg::CMD_AUTOSEL :
                    flash_host_pkg::CMD_BYPASS_EXIT};
            default: begin
                if (seq_len(op) == 3'd0 || (op == flash_host_pkg::OP_PROGRAM && i == 3'd3)) begin
                    seq_word = {a, d};
                end else if (k == 3'd0) seq_word = {flash_host_pkg::UNLOCK_ADDR1,
                    flash_host_pkg::UNLOCK_DATA1};
                else if (k == 3'd1) seq_word = {flash_host_pkg::UNLOCK_ADDR2,
                    flash_host_pkg::UNLOCK_DATA2};
                else if (i == 3'd2) begin
                    unique case (op)
                        flash_host_pkg::OP_RESET3:
                            seq_word = {a, flash_host_pkg::CMD_RESET};
                        flash_host_pkg::OP_AUTOSEL:
                            seq_word = {flash_host_pkg::UNLOCK_ADDR1, flash_host_pkg::CMD_AUTOSEL};
                        flash_host_pkg::OP_PROGRAM:
                            seq_word = {flash_host_pkg::UNLOCK_ADDR1, flash_host_pkg::CMD_PROGRAM};
                        flash_host_pkg::OP_BYPASS:
                            seq_word = {flash_host_pkg::UNLOCK_ADDR1, flash_host_pkg::CMD_BYPASS};
                        default:
                            seq_word = {flash_host_pkg::UNLOCK_ADDR1,
                                flash_host_pkg::CMD_ERASE_SETUP};
                    endcase
                end else if (i == 3'd5) begin
                    if (op == flash_host_pkg::OP_CHIP_ERASE)
                        seq_word = {flash_host_pkg::UNLOCK_ADDR1, flash_host_pkg::CMD_CHIP_ERASE};
                    else
                        seq_word = {a, flash_host_pkg::CMD_BLOCK_ERASE};
                end
            end
        endcase
    endfunction

    logic [26:0] word;
    assign word = seq_word(s_reg.op, s_reg.idx, s_reg.addr, s_reg.data);

    // Sequencer: one command at a time; writes go back to back with no reads between.
    always_comb begin
        s_next = s_reg;
        s_next.rsp = 1'b0;
        if (s_reg.gap_cnt != 32'd0) begin
            s_next.gap_cnt = s_reg.gap_cnt - 32'd1;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                if (cmd_valid) begin
                    s_next.op = flash_host_pkg::op_t'(cmd_op);
                    s_next.addr = cmd_addr;
                    s_next.data = cmd_data;
                    s_next.idx = 3'd0;
                    s_next.len = seq_len(flash_host_pkg::op_t'(cmd_op));
                    s_next.rd = (cmd_op == flash_host_pkg::OP_READ ||
                        cmd_op == flash_host_pkg::OP_ID_READ);
                    s_next.id_pin = (cmd_op == flash_host_pkg::OP_ID_READ);
                    s_next.st = ST_WRITE;
                end
            end
            ST_WRITE: begin
                s_next.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (cyc.done) begin
                    s_next.idx = s_reg.idx + 3'd1;
                    s_next.rdata = cyc.rdata;
                    if (s_reg.rd || s_reg.idx + 3'd1 >= s_reg.len) begin
                        s_next.st = ST_PAUSE;
                        s_next.wait_cnt = 32'd0;
                        unique case (s_reg.op)
                            flash_host_pkg::OP_RESET, flash_host_pkg::OP_RESET3: begin
                                // Device may still be aborting; hold off reads.
                                s_next.wait_cnt = 32'(ABORT_WAIT);
                            end
                            flash_host_pkg::OP_SUSPEND:
                                s_next.wait_cnt = 32'(SUSPEND_WAIT);
                            flash_host_pkg::OP_BYPASS: s_next.bypass = 1'b1;
                            flash_host_pkg::OP_BYP_EXIT: s_next.bypass = 1'b0;
                            flash_host_pkg::OP_BLOCK_ERASE, flash_host_pkg::OP_BLOCK_ADD:
                                s_next.gap_cnt = 32'(BLOCK_GAP);
                            default: ;
                        endcase
                    end else begin
                        s_next.st = ST_WRITE;
                    end
                end
            end
            ST_PAUSE: begin
                if (s_reg.wait_cnt == 32'd0) begin
                    s_next.st = ST_DONE;
                end else begin
                    s_next.wait_cnt = s_reg.wait_cnt - 32'd1;
                end
            end
            ST_DONE: begin
                s_next.rsp = 1'b1;
                s_next.id_pin = 1'b0;
                s_next.st = ST_IDLE;
            end
            default: s_next.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // A read request keeps the caller's address; writes take the sequence word.
    assign cyc.req = (s_reg.st == ST_WRITE);
    assign cyc.write = !s_reg.rd;
    assign cyc.addr = s_reg.rd ? s_reg.addr : word[26:8];
    assign cyc.data = word[7:0];
    assign cmd_ready = (s_reg.st == ST_IDLE);
    assign rsp_valid = s_reg.rsp;
    assign rsp_data = s_reg.rdata;
    assign bypass_active = s_reg.bypass;
    assign block_window_open = (s_reg.gap_cnt != 32'd0);
    assign elevated_id_voltage = s_reg.id_pin;

    flash_bus_cycle u_cycle (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .cyc(cyc),
        .chip_en_n(chip_en_n),
        .out_en_n(out_en_n),
        .write_en_n(write_en_n),
        .byte_address_lines(byte_address_lines),
        .byte_data_lines_out(byte_data_lines_out),
        .byte_data_lines_oe(byte_data_lines_oe),
        .byte_data_lines_in(byte_data_lines_in)
    );

    property p_unlock_first;
        @(posedge ref_clk) disable iff (reset)
        (cyc.req && s_reg.op == flash_host_pkg::OP_PROGRAM && s_reg.idx == 3'd0)
        |-> cyc.addr == flash_host_pkg::UNLOCK_ADDR1 && cyc.data == flash_host_pkg::UNLOCK_DATA1;
    endproperty
    a_unlock_first: assert property (p_unlock_first)
        else $error("Program does not open with the unlock write.");
    property p_reset_code;
        @(posedge ref_clk) disable iff (reset)
        (cyc.req && s_reg.op == flash_host_pkg::OP_RESET) |-> cyc.data == flash_host_pkg::CMD_RESET;
    endproperty
    a_reset_code: assert property (p_reset_code)
        else $error("Reset write carries the wrong code.");
    property p_abort_wait;
        @(posedge ref_clk) disable iff (reset || !clk_en)
        (s_reg.st == ST_WAIT && cyc.done && s_reg.op == flash_host_pkg::OP_RESET)
        |=> s_reg.wait_cnt == 32'(ABORT_WAIT);
    endproperty
    a_abort_wait: assert property (p_abort_wait)
        else $error("Reset hold-off not loaded.");
    property p_oe_never_read;
        @(posedge ref_clk) disable iff (reset)
        byte_data_lines_oe |-> out_en_n;
    endproperty
    a_oe_never_read: assert property (p_oe_never_read)
        else $error("Data driven during a read strobe.");
    property p_bypass_set;
        @(posedge ref_clk) disable iff (reset || !clk_en)
        (s_reg.st == ST_WAIT && cyc.done && s_reg.op == flash_host_pkg::OP_BYPASS &&
        s_reg.idx == 3'd2) |=> bypass_active;
    endproperty
    a_bypass_set: assert property (p_bypass_set)
        else $error("Bypass flag not set after entry.");
    property p_exit_code;
        @(posedge ref_clk) disable iff (reset)
        (cyc.req && s_reg.op == flash_host_pkg::OP_BYP_EXIT && s_reg.idx == 3'd1)
        |-> cyc.data == flash_host_pkg::CMD_BYPASS_EXIT;
    endproperty
    a_exit_code: assert property (p_exit_code)
        else $error("Bypass exit second write wrong.");
    property p_chip_last;
        @(posedge ref_clk) disable iff (reset)
        (cyc.req && s_reg.op == flash_host_pkg::OP_CHIP_ERASE && s_reg.idx == 3'd5)
        |-> cyc.data == flash_host_pkg::CMD_CHIP_ERASE && cyc.addr == flash_host_pkg::UNLOCK_ADDR1;
    endproperty
    a_chip_last: assert property (p_chip_last)
        else $error("Chip erase last write wrong.");
    property p_byp_first;
        @(posedge ref_clk) disable iff (reset)
        (cyc.req && s_reg.op == flash_host_pkg::OP_BYP_PROGRAM && s_reg.idx == 3'd0)
        |-> cyc.data == flash_host_pkg::CMD_PROGRAM;
    endproperty
    a_byp_first: assert property (p_byp_first)
        else $error("Bypass program first write wrong.");
    c_program: cover property (@(posedge ref_clk) s_reg.op == flash_host_pkg::OP_PROGRAM && rsp_valid);
    c_erase: cover property (@(posedge ref_clk) s_reg.op == flash_host_pkg::OP_BLOCK_ADD && rsp_valid);
    c_idread: cover property (@(posedge ref_clk) elevated_id_voltage && !out_en_n);
endmodule
`default_nettype wire

// *** inc/flash_host_pkg.sv ***
package flash_host_pkg;
    // Bus geometry of the attached part.
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // Command addresses and data codes.
    localparam logic [18:0] UNLOCK_ADDR1 = 19'h00555;
    localparam logic [18:0] UNLOCK_ADDR2 = 19'h002AA;
    localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
    // Auto select read offsets.
    localparam logic [18:0] AS_MAKER_ADDR = 19'h00000;
    localparam logic [18:0] AS_PART_ADDR = 19'h00001;
    localparam logic [18:0] AS_PROT_ADDR = 19'h00002;
    localparam int BLOCK_LSB = 16;
    // Timing at 200 MHz.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ABORT_TIME_US = 10;
    localparam int ABORT_CYCLES = ABORT_TIME_US * 1000000 / CLK_PERIOD_PS;
    localparam int BLOCK_GAP_US = 50;
    localparam int BLOCK_GAP_CYCLES = BLOCK_GAP_US * 1000000 / CLK_PERIOD_PS;
    localparam int SUSPEND_TIME_US = 15;
    localparam int SUSPEND_CYCLES = SUSPEND_TIME_US * 1000000 / CLK_PERIOD_PS;
    // Bus strobe phase lengths in cycles.
    localparam int SETUP_CYCLES = 2;
    localparam int STROBE_CYCLES = 4;
    localparam int HOLD_CYCLES = 2;
    // Host commands.
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_RESET = 4'h1, OP_RESET3 = 4'h2, OP_AUTOSEL = 4'h3,
        OP_PROGRAM = 4'h4, OP_BYPASS = 4'h5, OP_BYP_PROGRAM = 4'h6,
        OP_BYP_EXIT = 4'h7, OP_CHIP_ERASE = 4'h8, OP_BLOCK_ERASE = 4'h9,
        OP_BLOCK_ADD = 4'hA, OP_SUSPEND = 4'hB, OP_RESUME = 4'hC, OP_ID_READ = 4'hD
    } op_t;
endpackage

// *** inc/flash_cycle_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Carries one bus cycle request from the sequencer to the strobe engine.
interface flash_cycle_if;
    logic req;
    logic write;
    logic [18:0] addr;
    logic [7:0] data;
    logic done;
    logic [7:0] rdata;
    modport seq (output req, output write, output addr, output data,
        input done, input rdata);
    modport eng (input req, input write, input addr, input data,
        output done, output rdata);
endinterface
`default_nettype wire

// *** design/flash_bus_cycle.sv ***
`timescale 1ns/10ps
`default_nettype none
// Drives one read or write cycle on the flash strobes.
module flash_bus_cycle (
    // Clock and control.
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Request side.
    flash_cycle_if.eng cyc,
    // Flash pins.
    output logic chip_en_n,
    output logic out_en_n,
    output logic write_en_n,
    output logic [18:0] byte_address_lines,
    output logic [7:0] byte_data_lines_out,
    output logic byte_data_lines_oe,
    input wire logic [7:0] byte_data_lines_in
);
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00, PH_SETUP = 2'b01, PH_STROBE = 2'b11, PH_HOLD = 2'b10
    } phase_t;
    typedef struct packed {
        phase_t ph;
        logic [3:0] cnt;
        logic wr;
        logic [18:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done;
    } eng_t;
    eng_t s_reg, s_next;

    // Address is set before the strobe falls and data is held past its rise.
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.ph)
            PH_IDLE: begin
                if (cyc.req) begin
                    s_next.ph = PH_SETUP;
                    s_next.cnt = 4'(flash_host_pkg::SETUP_CYCLES - 1);
                    s_next.wr = cyc.write;
                    s_next.addr = cyc.addr;
                    s_next.wdata = cyc.data;
                end
            end
            PH_SETUP: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h0) begin
                    s_next.ph = PH_STROBE;
                    s_next.cnt = 4'(flash_host_pkg::STROBE_CYCLES - 1);
                end
            end
            PH_STROBE: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h0) begin
                    s_next.ph = PH_HOLD;
                    s_next.cnt = 4'(flash_host_pkg::HOLD_CYCLES - 1);
                    s_next.rdata = byte_data_lines_in;
                end
            end
            PH_HOLD: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h0) begin
                    s_next.ph = PH_IDLE;
                    s_next.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // Output enable stays high through a write so the pins never fight.
    assign chip_en_n = !(s_reg.ph == PH_STROBE);
    assign write_en_n = !(s_reg.ph == PH_STROBE && s_reg.wr);
    assign out_en_n = !(s_reg.ph == PH_STROBE && !s_reg.wr);
    assign byte_address_lines = s_reg.addr;
    assign byte_data_lines_out = s_reg.wdata;
    assign byte_data_lines_oe = s_reg.wr && s_reg.ph != PH_IDLE;
    assign cyc.done = s_reg.done;
    assign cyc.rdata = s_reg.rdata;

    // Both strobes low at once would let the part take a write while it drives the bus.
    property p_oe_excl;
        @(posedge ref_clk) disable iff (reset)
        !(!out_en_n && !write_en_n);
    endproperty
    a_oe_excl: assert property (p_oe_excl)
        else $error("Output and write enable low together.");
    property p_read_strobe;
        @(posedge ref_clk) disable iff (reset)
        !out_en_n |-> !chip_en_n && write_en_n && !byte_data_lines_oe;
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("Read strobe without chip enable or with a write active.");
endmodule
`default_nettype wire

// *** verif/flash_part_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Behavioural flash part. It finishes every operation at once, so no read sees a busy part.
module flash_part_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
    parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value.
    parameter logic [7:0] PROT_MASK = 8'h80
) (
    // Host strobes and buses.
    input wire logic chip_en_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic [18:0] byte_address_lines,
    input wire logic [7:0] host_data,
    input wire logic host_oe,
    input wire logic elevated_id_voltage,
    // Resolved data lines.
    output logic [7:0] bus_data
);
    logic [7:0] mem [0:524287];
    logic [18:0] lat_a;
    logic [7:0] q;
    logic autosel = 1'b0;
    logic bypass = 1'b0;
    int step = 0;
    int suspends = 0;
    wire logic wr_n = chip_en_n | write_en_n;
    // Blank array except one seeded byte in the protected block.
    initial begin
        for (int i = 0; i < 524288; i++) begin
            mem[i] = 8'hFF;
        end
        mem[19'h70010] = 8'hA5;
    end
    // Programming can only clear bits, and protected blocks are skipped silently.
    task automatic prog(input logic [18:0] a, input logic [7:0] d);
        if (!PROT_MASK[a[18:16]]) mem[a] = mem[a] & d;
    endtask
    task automatic erase(input logic [2:0] b);
        for (int j = 0; j < 65536; j++) begin
            if (!PROT_MASK[b]) mem[{b, 16'h0000} + j] = 8'hFF;
        end
    endtask
    // Address is taken as the write strobe falls.
    always @(negedge wr_n) lat_a = byte_address_lines;
    // Data is taken as it rises; any break in a sequence drops back to array read.
    always @(posedge wr_n) begin : decode
        logic [10:0] a;
        logic [7:0] d;
        a = lat_a[10:0];
        d = host_data;
        if (bypass && step == 0) step = (d == 8'hA0) ? 8 : (d == 8'h90) ? 9 : 0;
        else if (step == 8) begin prog(lat_a, d); step = 0; end
        else if (step == 9) begin bypass = (d != 8'h00); step = 0; end
        else if (step == 7 && d == 8'h30) erase(lat_a[18:16]);
        else if (step == 3) begin prog(lat_a, d); autosel = 1'b0; step = 0; end
        else if (step % 4 == 0 && a == 11'h555 && d == 8'hAA) step = step + 1;
        else if (step % 4 == 1 && a == 11'h2AA && d == 8'h55) step = step + 1;
        else if (step == 6 && a == 11'h555 && d == 8'h10) begin
            for (int b = 0; b < 8; b++) erase(b[2:0]);
            step = 0;
        end
        else if (step == 6 && d == 8'h30) begin erase(lat_a[18:16]); step = 7; end
        else if (step == 2 && a == 11'h555 && d == 8'h90) begin autosel = 1'b1; step = 0; end
        else if (step == 2 && a == 11'h555 && d == 8'hA0) step = 3;
        else if (step == 2 && a == 11'h555 && d == 8'h20) begin bypass = 1'b1; step = 0; end
        else if (step == 2 && a == 11'h555 && d == 8'h80) step = 4;
        else begin
            if (d == 8'hB0 || d == 8'h30) suspends++;
            autosel = 1'b0;
            step = 0;
        end
    end
    // Reads answer at once; an undriven bus shows the inverse so stale data never passes.
    always @* begin
        if ((elevated_id_voltage || autosel) && byte_address_lines[1:0] == 2'b00) q = MAKER_CODE;
        else if ((elevated_id_voltage || autosel) && byte_address_lines[1:0] == 2'b01) q = PART_CODE;
        else if (autosel && byte_address_lines[1:0] == 2'b10) q = {7'h00, PROT_MASK[byte_address_lines[18:16]]};
        else q = mem[byte_address_lines];
        if (host_oe) bus_data = host_data;
        else if (!chip_en_n && !out_en_n && write_en_n) bus_data = q;
        else bus_data = ~q;
    end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic [3:0] cmd_op = 4'h0;
    logic [18:0] cmd_addr = 19'h00000;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, rsp_valid, bypass_active, block_window_open;
    logic chip_en_n, out_en_n, write_en_n, dq_oe, id_hv;
    logic [7:0] rsp_data, dq_out, dq_in;
    logic [18:0] addr_lines;
    int fails = 0;
    int comparisons = 0;
    // Waits are shortened so the reset and window timers run in a few cycles.
    flash_command_host #(.ABORT_WAIT(20), .SUSPEND_WAIT(20), .BLOCK_GAP(20)) dut (
        .ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bypass_active(bypass_active),
        .block_window_open(block_window_open), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
        .write_en_n(write_en_n), .byte_address_lines(addr_lines), .byte_data_lines_out(dq_out),
        .byte_data_lines_oe(dq_oe), .byte_data_lines_in(dq_in), .elevated_id_voltage(id_hv));
    flash_part_model dev (
        .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .byte_address_lines(addr_lines), .host_data(dq_out), .host_oe(dq_oe),
        .elevated_id_voltage(id_hv), .bus_data(dq_in));
    always #2.5 ref_clk = ~ref_clk;
    task automatic wrap_up;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] act);
        comparisons++;
        if (act !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, act);
        end
    endtask
    // Every wait is bounded; running out ends the run as a mismatch.
    task automatic await(ref logic sig, input logic val);
        int n;
        n = 0;
        while (sig !== val) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > 5000) begin
                fails++;
                $display("BAD wait expected %b seen %b", val, sig);
                wrap_up();
            end
        end
    endtask
    // One command: request held until taken, then wait for the completion pulse.
    task automatic run(input logic [3:0] op, input logic [18:0] a, input logic [7:0] d);
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        await(cmd_ready, 1'b1);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        await(rsp_valid, 1'b1);
    endtask
    task automatic rd(input logic [18:0] a, input logic [7:0] exp, input string what);
        run(4'h0, a, 8'h00);
        check(what, exp, rsp_data);
    endtask
    task automatic t_program;
        run(4'h4, 19'h12345, 8'h3C);
        rd(19'h12345, 8'h3C, "programmed byte");
        run(4'h4, 19'h12345, 8'hF0);
        rd(19'h12345, 8'h30, "bits only cleared");
        run(4'h4, 19'h70010, 8'h00);
        rd(19'h70010, 8'hA5, "protected byte");
        run(4'h3, 19'h00555, 8'h00);
        run(4'hE, 19'h00555, 8'h77);
        rd(19'h12345, 8'h30, "read after broken sequence");
        $display("test program done");
    endtask
    task automatic t_autosel;
        run(4'h3, 19'h00555, 8'h00);
        rd(19'h40000, 8'h5A, "maker code");
        rd(19'h40001, 8'hC3, "part code");
        rd(19'h70002, 8'h01, "protected status");
        rd(19'h30002, 8'h00, "open status");
        run(4'h2, 19'h00000, 8'h00);
        rd(19'h12345, 8'h30, "read after long reset");
        run(4'h3, 19'h00555, 8'h00);
        run(4'h1, 19'h00000, 8'h00);
        rd(19'h12345, 8'h30, "read after short reset");
        run(4'hD, 19'h00001, 8'h00);
        check("signature read", 8'hC3, rsp_data);
        run(4'h3, 19'h00555, 8'h00);
        run(4'h4, 19'h12345, 8'h10);
        rd(19'h12345, 8'h10, "array read after program");
        $display("test auto select done");
    endtask
    task automatic t_bypass;
        run(4'h5, 19'h00555, 8'h00);
        check("bypass flag", 8'h01, {7'h00, bypass_active});
        run(4'h6, 19'h23456, 8'h5A);
        rd(19'h23456, 8'h5A, "bypass program");
        run(4'h1, 19'h00000, 8'h00);
        run(4'h6, 19'h23457, 8'h81);
        rd(19'h23457, 8'h81, "bypass kept over reset");
        run(4'h7, 19'h00000, 8'h00);
        check("bypass flag cleared", 8'h00, {7'h00, bypass_active});
        run(4'h6, 19'h23458, 8'h00);
        rd(19'h23458, 8'hFF, "no bypass after exit");
        $display("test bypass done");
    endtask
    task automatic t_erase;
        run(4'h9, 19'h10000, 8'h00);
        check("window open", 8'h01, {7'h00, block_window_open});
        run(4'hA, 19'h20000, 8'h00);
        await(block_window_open, 1'b0);
        rd(19'h12345, 8'hFF, "first block erased");
        rd(19'h23456, 8'hFF, "added block erased");
        run(4'hB, 19'h00000, 8'h00);
        run(4'hC, 19'h00000, 8'h00);
        check("suspend and resume writes", 8'h02, dev.suspends[7:0]);
        run(4'h4, 19'h00100, 8'h00);
        run(4'h8, 19'h00555, 8'h00);
        rd(19'h00100, 8'hFF, "chip erased");
        rd(19'h70010, 8'hA5, "protected block kept");
        $display("test erase done");
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        t_program();
        t_autosel();
        t_bypass();
        t_erase();
        wrap_up();
    end
endmodule
`default_nettype wire
